// >>> misc_port_device.sv
`timescale 1ns/1ps
`default_nettype none
module misc_port_device
   import misc_port_pkg::*;
#(
   parameter int ram_depth = clock_ram_depth
)
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   misc_port_if.device bus,
   input wire logic keyboard_irq_event_in,
   input wire logic aux_irq_event_in,
   input wire logic parity_error_in,
   input wire logic channel_check_error_in,
   input wire logic channel_acknowledge_in,
   input wire logic [3:0] memory_presence_in,
   input wire logic id_high_write_in,
   input wire logic [7:0] id_high_data_in,
   output logic keyboard_interrupt_request_out,
   output logic aux_device_interrupt_request_out,
   output logic timer2_gate_out,
   output logic speaker_data_enable_out,
   output logic nmi_mask_out,
   output logic board_enable_out,
   output logic board_enable_copy_wr_out,
   output logic video_setup_n_out,
   output logic [7:0] option_select_out,
   output logic onboard_video_enable_pin_out
);
   import misc_port_pkg::*;

   // ****************************************
   // decode
   // ****************************************
   logic hit_kbd, hit_portb, hit_idx, hit_data, hit_ack, hit_setup;
   logic hit_idl, hit_idh, hit_opt, hit_mem, hit_vid;
   logic rd, wr;
   // full 16-bit compare, no aliasing
   assign hit_kbd = (bus.io_addr == keyboard_data_port_addr);
   assign hit_portb = (bus.io_addr == system_control_port_b_addr);
   assign hit_idx = (bus.io_addr == clock_ram_index_addr);
   assign hit_data = (bus.io_addr == clock_ram_data_addr);
   assign hit_ack = (bus.io_addr == channel_acknowledge_addr);
   assign hit_setup = (bus.io_addr == setup_enable_addr);
   assign hit_idl = (bus.io_addr == board_id_low_addr);
   assign hit_idh = (bus.io_addr == board_id_high_addr);
   assign hit_opt = (bus.io_addr == option_select_addr);
   assign hit_mem = (bus.io_addr == memory_presence_addr);
   assign hit_vid = (bus.io_addr == video_enable_addr);
   assign rd = bus.io_rd && clk_en_in;
   assign wr = bus.io_wr && clk_en_in;

   // ****************************************
   // state
   // ****************************************
   logic kbd_irq_reg, aux_irq_reg;
   logic [3:0] portb_reg;
   logic [6:0] index_reg;
   logic nmi_mask_reg;
   logic [7:0] setup_reg;
   logic [7:0] option_reg;
   logic video_en_reg;
   logic [7:0] id_high_reg;
   logic copy_wr_reg;
   logic [7:0] clock_ram [ram_depth];
   logic [7:0] rdata_reg;
   logic rvalid_reg;

   // interrupt latches; a read clears, a new event in the same cycle wins
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         kbd_irq_reg <= 1'b0;
         aux_irq_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (keyboard_irq_event_in) begin
            kbd_irq_reg <= 1'b1;
         end else if (rd && hit_kbd) begin
            kbd_irq_reg <= 1'b0;
         end
         if (aux_irq_event_in) begin
            aux_irq_reg <= 1'b1;
         end else if (rd && hit_kbd) begin
            aux_irq_reg <= 1'b0;
         end
      end
   end

   // port B control bits; bits 7..4 of the write are dropped
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         portb_reg <= portb_ctrl_reset;
      end else if (wr && hit_portb) begin
         portb_reg <= bus.io_wdata[3:0];
      end
   end

   // clock RAM index and nmi mask
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         index_reg <= 7'h00;
         nmi_mask_reg <= nmi_mask_reset;
      end else if (wr && hit_idx) begin
         index_reg <= bus.io_wdata[6:0];
         nmi_mask_reg <= bus.io_wdata[nmi_mask_bit];
      end
   end

   // clock RAM array, no reset: contents are battery-backed in spirit
   always_ff @(posedge clk_sys_in) begin
      if (wr && hit_data) begin
         clock_ram[index_reg] <= bus.io_wdata;
      end
   end

   // setup, option and video ports; presence writes dropped
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         setup_reg <= setup_enable_reset;
         option_reg <= option_select_reset;
         video_en_reg <= video_enable_reset;
         copy_wr_reg <= 1'b0;
      end else if (clk_en_in) begin
         copy_wr_reg <= wr && hit_setup; // pulse tells other devices to copy
         if (wr && hit_setup) begin
            setup_reg[setup_board_en_bit] <= bus.io_wdata[setup_board_en_bit];
            setup_reg[setup_video_en_bit] <= bus.io_wdata[setup_video_en_bit];
         end
         if (wr && hit_opt) begin
            option_reg <= bus.io_wdata;
         end
         if (wr && hit_vid) begin
            video_en_reg <= bus.io_wdata[0];
         end
      end
   end

   // id high byte, loaded from the id_high_write_in / id_high_data_in side inputs
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         id_high_reg <= board_id_high_reset;
      end else if (clk_en_in && id_high_write_in) begin
         id_high_reg <= id_high_data_in;
      end
   end

   // ****************************************
   // read mux
   // ****************************************
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00; // unused bits and unmapped ports read zero
      if (hit_portb) begin
         rmux[portb_parity_err_bit] = parity_error_in;
         rmux[portb_channel_err_bit] = channel_check_error_in;
         rmux[3:0] = portb_reg;
      end else if (hit_idx) begin
         rmux[6:0] = index_reg; // mask bit is write only
      end else if (hit_data) begin
         rmux = clock_ram[index_reg];
      end else if (hit_ack) begin
         rmux[0] = channel_acknowledge_in;
      end else if (hit_setup) begin
         rmux[setup_board_en_bit] = setup_reg[setup_board_en_bit];
         rmux[setup_video_en_bit] = setup_reg[setup_video_en_bit];
      end else if (hit_idl) begin
         rmux = board_id_low_value;
      end else if (hit_idh) begin
         // only visible in setup mode
         rmux = setup_reg[setup_board_en_bit] ? 8'h00 : id_high_reg;
      end else if (hit_opt) begin
         rmux = option_reg;
      end else if (hit_mem) begin
         rmux[3:0] = memory_presence_in;
      end else if (hit_vid) begin
         rmux[0] = video_en_reg;
      end
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else if (clk_en_in) begin
         rvalid_reg <= rd;
         rdata_reg <= rd ? rmux : 8'h00;
      end
   end

   assign bus.io_rdata = rdata_reg;
   assign bus.io_rdata_valid = rvalid_reg;
   assign keyboard_interrupt_request_out = kbd_irq_reg;
   assign aux_device_interrupt_request_out = aux_irq_reg;
   assign timer2_gate_out = portb_reg[portb_timer2_gate_bit];
   assign speaker_data_enable_out = portb_reg[portb_speaker_data_bit];
   assign nmi_mask_out = nmi_mask_reg;
   assign board_enable_out = setup_reg[setup_board_en_bit];
   assign board_enable_copy_wr_out = copy_wr_reg;
   assign video_setup_n_out = setup_reg[setup_video_en_bit];
   assign option_select_out = option_reg;
   assign onboard_video_enable_pin_out = video_en_reg;
endmodule : misc_port_device
`default_nettype wire

// >>> misc_port_pkg.sv
package misc_port_pkg;
   // ****************************************
   // port addresses
   // ****************************************
   localparam logic [15:0] keyboard_data_port_addr = 16'h0060;
   localparam logic [15:0] system_control_port_b_addr = 16'h0061;
   localparam logic [15:0] clock_ram_index_addr = 16'h0070;
   localparam logic [15:0] clock_ram_data_addr = 16'h0071;
   localparam logic [15:0] channel_acknowledge_addr = 16'h0091;
   localparam logic [15:0] setup_enable_addr = 16'h0094;
   localparam logic [15:0] board_id_low_addr = 16'h0100;
   localparam logic [15:0] board_id_high_addr = 16'h0101;
   localparam logic [15:0] option_select_addr = 16'h0102;
   localparam logic [15:0] memory_presence_addr = 16'h0103;
   localparam logic [15:0] video_enable_addr = 16'h03C3;
   // ****************************************
   // field positions
   // ****************************************
   localparam int portb_parity_err_bit = 7;
   localparam int portb_channel_err_bit = 6;
   localparam int portb_channel_dis_bit = 3;
   localparam int portb_parity_dis_bit = 2;
   localparam int portb_speaker_data_bit = 1;
   localparam int portb_timer2_gate_bit = 0;
   localparam int nmi_mask_bit = 7;
   localparam int setup_board_en_bit = 7;
   localparam int setup_video_en_bit = 5;
   // ****************************************
   // reset values and sizes
   // ****************************************
   localparam logic [3:0] portb_ctrl_reset = 4'hC;
   localparam logic [7:0] setup_enable_reset = 8'hA0;
   localparam logic [7:0] option_select_reset = 8'h00;
   localparam logic nmi_mask_reset = 1'b1;
   localparam logic video_enable_reset = 1'b1;
   localparam int clock_ram_depth = 128;
   // arbitrary identity bytes, not taken from any part
   localparam logic [7:0] board_id_low_value = 8'h5A;
   localparam logic [7:0] board_id_high_reset = 8'h3C;
endpackage : misc_port_pkg

// >>> misc_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface misc_port_if;
   logic [15:0] io_addr;
   logic [7:0] io_wdata;
   logic io_rd;
   logic io_wr;
   logic [7:0] io_rdata;
   logic io_rdata_valid;
   modport device (input io_addr, input io_wdata, input io_rd, input io_wr, output io_rdata, output io_rdata_valid);
   modport host (output io_addr, output io_wdata, output io_rd, output io_wr, input io_rdata, input io_rdata_valid);
endinterface : misc_port_if
`default_nettype wire

// >>> misc_port_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host end: one i/o cycle per request
// ****************************************
module misc_port_host
   import misc_port_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   misc_port_if.host bus,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [15:0] req_addr_in,
   input wire logic [7:0] req_wdata_in,
   output logic req_ready_out,
   output logic [7:0] rsp_data_out,
   output logic rsp_valid_out
);
   import misc_port_pkg::*;

   typedef enum logic [1:0] {idle_s = 2'b00, strobe_s = 2'b01, done_s = 2'b11} host_state_t;
   host_state_t state_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic write_reg;
   logic [7:0] rdata_reg;
   logic rsp_reg;

   // one request at a time keeps index-then-data order intact
   assign req_ready_out = (state_reg == idle_s);
   assign rsp_data_out = rdata_reg;
   assign rsp_valid_out = rsp_reg;
   assign bus.io_addr = addr_reg;
   assign bus.io_wdata = wdata_reg;
   assign bus.io_rd = (state_reg == strobe_s) && !write_reg;
   assign bus.io_wr = (state_reg == strobe_s) && write_reg;

   // sequencer: latch, strobe one cycle, report
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= idle_s;
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         write_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rsp_reg <= 1'b0;
      end else if (clk_en_in) begin
         rsp_reg <= 1'b0;
         case (state_reg)
            idle_s: begin
               if (req_valid_in) begin
                  addr_reg <= req_addr_in;
                  wdata_reg <= req_wdata_in;
                  write_reg <= req_write_in;
                  state_reg <= strobe_s;
               end
            end
            strobe_s: begin
               state_reg <= done_s;
            end
            done_s: begin
               // the device answers one cycle after the strobe, so take the byte here
               if (!write_reg) begin
                  rdata_reg <= bus.io_rdata;
               end
               rsp_reg <= 1'b1;
               state_reg <= idle_s;
            end
            default: state_reg <= idle_s;
         endcase
      end
   end
endmodule : misc_port_host
`default_nettype wire

// >>> misc_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bus checks between host and device
// ****************************************
module misc_port_props
   import misc_port_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_valid
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   // answer timing: the bench drops clk_en_in only while the bus is idle
   AST_RD_ANSWER: assert property (io_rd |=> io_rdata_valid) else $error("read not answered");
   AST_NO_SPURIOUS: assert property ($rose(io_rdata_valid) |-> $past(io_rd)) else $error("stray valid");
   AST_IDLE_ZERO: assert property (!io_rdata_valid |-> io_rdata == 8'h00) else $error("data off cycle");
   AST_WR_SILENT: assert property (io_wr && !io_rd |=> !io_rdata_valid) else $error("write answered");
   AST_PULSE: assert property ((!io_rd && !io_wr) [*2] |-> !io_rdata_valid) else $error("valid stuck");
   AST_ID_LOW: assert property (io_rd && io_addr == board_id_low_addr |=> io_rdata == board_id_low_value)
      else $error("id low wrong");
   AST_PRES_HI: assert property (io_rd && io_addr == memory_presence_addr |=> io_rdata[7:4] == 4'h0)
      else $error("presence top");
   AST_ACK_UNUSED: assert property (io_rd && io_addr == channel_acknowledge_addr |=> io_rdata[7:1] == 7'h00)
      else $error("ack unused bits");
   AST_VID_UNUSED: assert property (io_rd && io_addr == video_enable_addr |=> io_rdata[7:1] == 7'h00)
      else $error("video unused bits");
   AST_SETUP_UNUSED: assert property (io_rd && io_addr == setup_enable_addr |=> {io_rdata[6], io_rdata[4:0]} == 6'h00)
      else $error("setup unused bits");
   AST_UNMAPPED: assert property (io_rd && io_addr[15:10] != 6'h00 |=> io_rdata == 8'h00)
      else $error("unmapped read");
   // main scenarios
   COV_RAM: cover property (io_wr && io_addr == clock_ram_data_addr);
   COV_PRES: cover property (io_rd && io_addr == memory_presence_addr);
   COV_B2B: cover property (io_wr && io_addr == clock_ram_index_addr ##[1:8] io_rd && io_addr == clock_ram_data_addr);
endmodule : misc_port_props
`default_nettype wire

// >>> system_misc_port_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench: host drives device over the bus
// ****************************************
module system_misc_port_bank_tb_top;
   import misc_port_pkg::*;
   logic clk_sys_in = 0, resetn_in = 0, vld = 0, wr = 0, kb = 0, aux = 0, par = 0, chn = 0, ack = 0, idw = 0, ce = 1;
   logic [15:0] adr = 16'h0000;
   logic [7:0] wd = 8'h00, idd = 8'h00, q, rd, opt;
   logic [3:0] pres = 4'h0;
   logic [31:0] v;
   logic rdy, rv, kbo, auxo, t2, spk, nmi, be, bew, vsn, vpin;
   int failures = 0, cmp_count = 0, cyc = 0, seed = 32'h05AB, i, copy_n = 0;
   int ram[128];
   int wq[$];
   misc_port_if bus_if();
   misc_port_host misc_port_host_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(ce),
      .bus(bus_if), .req_valid_in(vld), .req_write_in(wr), .req_addr_in(adr), .req_wdata_in(wd),
      .req_ready_out(rdy), .rsp_data_out(rd), .rsp_valid_out(rv));
   misc_port_device misc_port_device_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(ce),
      .bus(bus_if), .keyboard_irq_event_in(kb), .aux_irq_event_in(aux), .parity_error_in(par),
      .channel_check_error_in(chn), .channel_acknowledge_in(ack), .memory_presence_in(pres),
      .id_high_write_in(idw), .id_high_data_in(idd), .keyboard_interrupt_request_out(kbo),
      .aux_device_interrupt_request_out(auxo), .timer2_gate_out(t2), .speaker_data_enable_out(spk),
      .nmi_mask_out(nmi), .board_enable_out(be), .board_enable_copy_wr_out(bew), .video_setup_n_out(vsn),
      .option_select_out(opt), .onboard_video_enable_pin_out(vpin));
   misc_port_props misc_port_props_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata), .io_rd(bus_if.io_rd), .io_wr(bus_if.io_wr),
      .io_rdata(bus_if.io_rdata), .io_rdata_valid(bus_if.io_rdata_valid));
   // 200 MHz clock, and a cycle ceiling so a hang still reports
   always #2.5 clk_sys_in = ~clk_sys_in;
   // copy pulses counted mid-cycle, away from the edge that launches them
   always @(negedge clk_sys_in) begin
      if (bew === 1'b1) copy_n++;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end
   task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask : chk
   // one request, waits for the answer pulse before returning
   task io(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      @(negedge clk_sys_in);
      vld = 1;
      wr = w;
      adr = a;
      wd = d;
      @(negedge clk_sys_in);
      vld = 0;
      chk("busy", {7'h00, rdy}, 8'h00);
      for (n = 0; n < 8 && rv !== 1'b1; n++) @(negedge clk_sys_in);
      chk("rsp", {7'h00, rv}, 8'h01);
      q = rd;
   endtask : io
   task summarize();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   // main sequence; expectations come from the bench's own model
   initial begin
      repeat (5) @(negedge clk_sys_in);
      resetn_in = 1;
      io(0, setup_enable_addr, 8'h00); chk("setup", q, 8'hA0);
      io(0, video_enable_addr, 8'h00); chk("video", q, 8'h01);
      io(0, board_id_high_addr, 8'h00); chk("idh", q, 8'h00);
      io(0, board_id_low_addr, 8'h00); chk("idl", q, board_id_low_value);
      chk("nmi", {7'h00, nmi}, 8'h01);
      io(0, system_control_port_b_addr, 8'h00); chk("portb rst", q, {4'h0, portb_ctrl_reset});
      $display("reset test done");
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         par = v[8];
         chn = v[9];
         io(1, system_control_port_b_addr, v[7:0]);
         io(0, system_control_port_b_addr, 8'h00); chk("portb", q & 8'hCF, {par, chn, 2'b00, v[3:0]});
         chk("spk", {6'h00, spk, t2}, {6'h00, v[1:0]});
      end
      $display("port b test done");
      for (i = 0; i < 6; i++) begin
         v = $random(seed);
         wq.push_back(v[14:8]);
         io(1, clock_ram_index_addr, {v[7], v[14:8]});
         chk("nmi", {7'h00, nmi}, {7'h00, v[7]});
         io(1, clock_ram_data_addr, v[23:16]); // no irq event between index and data
         ram[v[14:8]] = v[23:16];
      end
      foreach (wq[i]) begin
         io(1, clock_ram_index_addr, {1'b1, wq[i][6:0]});
         io(0, clock_ram_index_addr, 8'h00); chk("index", q & 8'h7F, wq[i][7:0]);
         io(0, clock_ram_data_addr, 8'h00); chk("ram", q, ram[wq[i]][7:0]);
      end
      $display("clock ram test done");
      v = $random(seed);
      @(negedge clk_sys_in);
      idw = 1;
      idd = v[7:0];
      pres = v[11:8];
      @(negedge clk_sys_in);
      idw = 0;
      io(1, setup_enable_addr, 8'h00); chk("setup out", {6'h00, be, vsn}, 8'h00);
      io(0, board_id_high_addr, 8'h00); chk("idh setup", q, v[7:0]);
      io(0, memory_presence_addr, 8'h00); chk("pres", q, {4'h0, v[11:8]});
      io(1, memory_presence_addr, 8'hFF);
      io(0, memory_presence_addr, 8'h00); chk("pres wr", q, {4'h0, v[11:8]});
      io(1, setup_enable_addr, 8'hFF);
      io(0, setup_enable_addr, 8'h00); chk("setup ff", q, 8'hA0);
      chk("setup out ff", {6'h00, be, vsn}, 8'h03);
      io(0, board_id_high_addr, 8'h00); chk("idh run", q, 8'h00);
      chk("copy pulses", copy_n[7:0], 8'h02);
      $display("setup test done");
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         ack = v[9];
         io(1, video_enable_addr, v[7:0]);
         io(0, video_enable_addr, 8'h00); chk("video", q, {7'h00, v[0]});
         chk("vpin", {7'h00, vpin}, {7'h00, v[0]});
         io(1, option_select_addr, v[15:8]);
         io(0, option_select_addr, 8'h00); chk("opt", q, v[15:8]);
         chk("opt out", opt, v[15:8]);
         io(0, channel_acknowledge_addr, 8'h00); chk("ack", q, {7'h00, ack});
      end
      $display("option test done");
      @(negedge clk_sys_in);
      kb = 1;
      aux = 1;
      @(negedge clk_sys_in);
      kb = 0;
      aux = 0;
      @(negedge clk_sys_in);
      chk("irq set", {6'h00, kbo, auxo}, 8'h03);
      io(0, keyboard_data_port_addr, 8'h00); chk("irq clr", {6'h00, kbo, auxo}, 8'h00);
      io(1, 16'h0062, 8'h5A);
      io(0, 16'h0062, 8'h00); chk("unmapped", q, 8'h00);
      // an alias of the keyboard port must read zero and not clear the request
      @(negedge clk_sys_in);
      kb = 1;
      @(negedge clk_sys_in);
      kb = 0;
      io(0, 16'h4060, 8'h00); chk("alias", q, 8'h00);
      chk("alias irq", {7'h00, kbo}, 8'h01);
      io(0, keyboard_data_port_addr, 8'h00); chk("irq clr2", {6'h00, kbo, auxo}, 8'h00);
      // clock enable low: an event must not reach the latch
      @(negedge clk_sys_in);
      ce = 0;
      aux = 1;
      @(negedge clk_sys_in);
      aux = 0;
      ce = 1;
      chk("frozen", {6'h00, kbo, auxo}, 8'h00);
      $display("irq test done");
      summarize();
   end
endmodule : system_misc_port_bank_tb_top
`default_nettype wire
